// >>> src/bus_cond_detect.sv
`timescale 1ns/100ps
`default_nettype none
module bus_cond_detect (
	input  wire logic clk,        // System clock
	input  wire logic reset,      // Async reset, high
	input  wire logic scl,        // Bus clock level
	input  wire logic sda,        // Bus data level
	output logic      scl_rise,   // Clock rose
	output logic      scl_fall,   // Clock fell
	output logic      start_seen, // Start condition
	output logic      stop_seen   // Stop condition
);
	logic scl_p_q;
	logic sda_p_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl;
			sda_p_q <= sda;
		end
	end

	// ========================================
	// Clock edges, and data edges while clock stays high
	assign scl_rise   = scl & ~scl_p_q;
	assign scl_fall   = ~scl & scl_p_q;
	assign start_seen = scl & scl_p_q & sda_p_q & ~sda;
	assign stop_seen  = scl & scl_p_q & ~sda_p_q & sda;
endmodule
`default_nettype wire

// >>> src/eeprom_master_end.sv
`timescale 1ns/100ps
`default_nettype none
module eeprom_master_end (
	input  wire logic            clk,       // System clock
	input  wire logic            reset,     // Async reset, high
	i2c_link_if.host             link,      // Two-wire bus
	input  wire logic            cmd_valid, // Operation request
	output logic                 cmd_ready, // Ready for operation
	input  wire eeprom_pkg::op_t cmd_op,    // Operation code
	input  wire logic [7:0]      cmd_data,  // Byte to write
	input  wire logic            cmd_ack,   // Acknowledge a read byte
	output logic                 done,      // Operation finished
	output logic [7:0]           rd_data,   // Last byte read
	output logic                 ack_seen   // Device acknowledged
);
	eeprom_pkg::op_t op_q;
	logic            run_q;
	logic [3:0]      slot_q;
	logic [1:0]      quarter_q;
	logic [4:0]      div_q;
	logic [8:0]      shift_q;
	logic [7:0]      rx_q;
	logic            ack_q;
	logic            scl_q;
	logic            oe_q;
	logic            done_q;

	// ========================================
	// Slot decoding
	wire is_byte  = (op_q == eeprom_pkg::OP_WRITE) ||
		(op_q == eeprom_pkg::OP_READ);
	wire is_rec   = (op_q == eeprom_pkg::OP_RECOVER);
	wire is_stop  = (op_q == eeprom_pkg::OP_STOP);
	wire bit_slot = (is_byte && slot_q <= eeprom_pkg::LAST_SLOT) ||
		(is_rec && slot_q < eeprom_pkg::RECOVER_LAST);
	wire last     = is_rec ? (slot_q == eeprom_pkg::RECOVER_LAST) :
		is_byte ? (slot_q == eeprom_pkg::LAST_SLOT) : 1'b1;
	wire tick     = run_q && (div_q == eeprom_pkg::QUARTER_LAST);
	wire pat_scl  = bit_slot ? quarter_q[1] : (quarter_q != 2'h0);
	wire pat_rel  = bit_slot ? shift_q[8] :
		(is_stop ? quarter_q[1] : ~quarter_q[1]);
	wire [8:0] load = (cmd_op == eeprom_pkg::OP_WRITE) ? {cmd_data, 1'b1} :
		(cmd_op == eeprom_pkg::OP_READ) ? {8'hff, ~cmd_ack} : 9'h1ff;

	// ========================================
	// Bit sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			op_q      <= eeprom_pkg::OP_START;
			run_q     <= 1'b0;
			slot_q    <= 4'h0;
			quarter_q <= 2'h0;
			div_q     <= 5'h00;
			shift_q   <= 9'h1ff;
			rx_q      <= 8'h00;
			ack_q     <= 1'b0;
			scl_q     <= 1'b1;
			oe_q      <= 1'b0;
			done_q    <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!run_q) begin
				if (cmd_valid) begin
					run_q     <= 1'b1;
					op_q      <= cmd_op;
					slot_q    <= 4'h0;
					quarter_q <= 2'h0;
					div_q     <= 5'h00;
					shift_q   <= load;
				end
			end else begin
				scl_q <= pat_scl;
				oe_q  <= ~pat_rel;
				div_q <= tick ? 5'h00 : div_q + 5'h01;
				if (tick) begin
					quarter_q <= quarter_q + 2'h1;
					if (quarter_q == 2'h2 && bit_slot && is_byte) begin
						if (slot_q < eeprom_pkg::ACK_SLOT) begin
							rx_q <= {rx_q[6:0], link.sda};
						end else if (op_q == eeprom_pkg::OP_WRITE) begin
							ack_q <= ~link.sda;
						end
					end
					if (quarter_q == 2'h3) begin
						if (bit_slot) begin
							shift_q <= {shift_q[7:0], 1'b1};
						end
						if (last) begin
							run_q  <= 1'b0;
							done_q <= 1'b1;
						end else begin
							slot_q <= slot_q + 4'h1;
						end
					end
				end
			end
		end
	end

	assign cmd_ready        = ~run_q;
	assign done             = done_q;
	assign rd_data          = rx_q;
	assign ack_seen         = ack_q;
	assign link.scl         = scl_q;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = oe_q;
endmodule
`default_nettype wire

// >>> src/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;
	// ========================================
	// Clock and timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int SCL_HZ        = 100_000;
	localparam int QUARTER_COUNT = CLK_HZ / (4 * SCL_HZ);
	localparam logic [4:0] QUARTER_LAST = 5'(QUARTER_COUNT - 1);
	localparam int WRITE_TIME_MS = 3;
	localparam int WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / 1000);
	localparam int RECOVER_CLOCKS = 9;

	// ========================================
	// Addressing
	localparam int ADDR_W    = 14;
	localparam int MEM_DEPTH = 16384;
	localparam int PAGE_BITS = 6;
	localparam int BYTE_BITS = 8;
	// Type code value is arbitrary
	localparam logic [3:0] TYPE_CODE = 4'h5;
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam logic [1:0] REGION_CFG = 2'h2;
	localparam logic [3:0] ACK_SLOT  = 4'h8;
	localparam logic [3:0] LAST_SLOT = 4'h8;
	localparam logic [3:0] RECOVER_LAST = 4'(RECOVER_CLOCKS);

	// ========================================
	// Master operations
	typedef enum logic [2:0] {
		OP_START   = 3'h0,
		OP_STOP    = 3'h1,
		OP_WRITE   = 3'h2,
		OP_READ    = 3'h3,
		OP_RECOVER = 3'h4
	} op_t;
endpackage
`default_nettype wire

// >>> src/eeprom_slave_end.sv
// Summary of operation
// - Data fall with clock high is start
// - Data rise with clock high is stop
// - Data changes only while clock low
// - Sample on clock rise, shift on fall
// - Eight-bit words, low acknowledge on ninth clock
// - Data line only pulled low or released
// - Master recovers with nine clocks, then start
// - Device address: type code, three select bits
// - Address bit zero high means read
// - Fourteen-bit word address in two bytes
// - Byte write: address, two bytes, data, stop
// - Programming cycle after write stop ignores bus
// - Programming finishes within three milliseconds
// - Page write: up to 63 more bytes
// - Write address wraps inside 64-byte page
// - Counter holds last address plus one
// - Read counter wraps over whole array
// - Current read: send byte at counter
// - Random read: dummy write, repeated start, read
// - Sequential read continues while master acknowledges
// - Standby at power-up and after stop
// - Config location write sets select bits
`timescale 1ns/100ps
`default_nettype none
module eeprom_slave_end #(
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
	input  wire logic       clk,        // System clock
	input  wire logic       reset,      // Async reset, high
	i2c_link_if.device      link,       // Two-wire bus
	output logic            standby,    // Idle, low power
	output logic            write_busy, // Programming cycle
	output logic [2:0]      sel_bits    // Current select bits
);
	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_DEV   = 7'h02,
		S_AHI   = 7'h04,
		S_ALO   = 7'h08,
		S_WDATA = 7'h10,
		S_RDATA = 7'h20,
		S_BUSY  = 7'h40
	} state_t;

	localparam logic [15:0] WRITE_LOAD =
		16'((WRITE_CYCLES > 1) ? WRITE_CYCLES - 1 : 0);

	state_t                  state_q;
	logic [3:0]              bit_q;
	logic [7:0]              in_q;
	logic [7:0]              out_q;
	logic                    drive_q;
	logic                    nine_q;
	logic [eeprom_pkg::ADDR_W-1:0] cnt_q;
	logic [7:0]              hi_q;
	logic [2:0]              sel_q;
	logic                    wrote_q;
	logic [15:0]             timer_q;
	logic [7:0]              mem [0:eeprom_pkg::MEM_DEPTH-1];

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	bus_cond_detect bus_cond_detect_i (
		.clk        (clk),
		.reset      (reset),
		.scl        (link.scl),
		.sda        (link.sda),
		.scl_rise   (scl_rise),
		.scl_fall   (scl_fall),
		.start_seen (start_seen),
		.stop_seen  (stop_seen)
	);

	// ========================================
	// Decoding
	wire       active     = (state_q != S_IDLE);
	wire       byte_done  = scl_fall & (bit_q == eeprom_pkg::ACK_SLOT);
	wire       addr_match = (in_q[7:4] == eeprom_pkg::TYPE_CODE) &&
		(in_q[3:1] == sel_q);
	wire       region_mem = ~hi_q[7];
	wire       region_cfg = (hi_q[7:6] == eeprom_pkg::REGION_CFG);
	wire [7:0] mem_rd     = mem[cnt_q];
	wire [2:0] out_idx    = 3'd7 - bit_q[2:0];
	wire [eeprom_pkg::PAGE_BITS-1:0] page_low =
		cnt_q[eeprom_pkg::PAGE_BITS-1:0] + 6'h1;
	wire mem_we = byte_done & (state_q == S_WDATA) & region_mem;

	// ========================================
	// Array storage
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[cnt_q] <= in_q;
		end
	end

	// ========================================
	// Protocol engine
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= S_IDLE;
			bit_q   <= 4'h0;
			in_q    <= 8'h00;
			out_q   <= 8'h00;
			drive_q <= 1'b0;
			nine_q  <= 1'b0;
			cnt_q   <= '0;
			hi_q    <= 8'h00;
			sel_q   <= eeprom_pkg::SEL_RESET;
			wrote_q <= 1'b0;
			timer_q <= 16'h0000;
		end else if (state_q == S_BUSY) begin
			drive_q <= 1'b0;
			if (timer_q == 16'h0000) begin
				state_q <= S_IDLE;
			end else begin
				timer_q <= timer_q - 16'h0001;
			end
		end else if (start_seen) begin
			state_q <= S_DEV;
			bit_q   <= 4'h0;
			drive_q <= 1'b0;
			nine_q  <= 1'b0;
			wrote_q <= 1'b0;
		end else if (stop_seen) begin
			drive_q <= 1'b0;
			nine_q  <= 1'b0;
			if (state_q == S_WDATA && wrote_q) begin
				state_q <= S_BUSY;
				timer_q <= WRITE_LOAD;
			end else begin
				state_q <= S_IDLE;
			end
		end else if (scl_rise && active) begin
			if (bit_q == eeprom_pkg::ACK_SLOT) begin
				bit_q  <= 4'h0;
				nine_q <= 1'b1;
				if (state_q == S_RDATA && !drive_q) begin
					if (!link.sda) begin
						out_q <= mem_rd;
					end else begin
						state_q <= S_IDLE;
					end
				end
			end else begin
				in_q  <= {in_q[6:0], link.sda};
				bit_q <= bit_q + 4'h1;
			end
		end else if (scl_fall && active) begin
			if (nine_q) begin
				nine_q  <= 1'b0;
				drive_q <= (state_q == S_RDATA) & ~out_q[7];
			end else if (bit_q == eeprom_pkg::ACK_SLOT) begin
				unique case (state_q)
					S_DEV: begin
						if (addr_match) begin
							drive_q <= 1'b1;
							if (in_q[0]) begin
								state_q <= S_RDATA;
								out_q   <= mem_rd;
							end else begin
								state_q <= S_AHI;
							end
						end else begin
							state_q <= S_IDLE;
						end
					end
					S_AHI: begin
						hi_q    <= in_q;
						drive_q <= 1'b1;
						state_q <= S_ALO;
					end
					S_ALO: begin
						cnt_q   <= {hi_q[5:0], in_q};
						drive_q <= 1'b1;
						state_q <= S_WDATA;
					end
					S_WDATA: begin
						drive_q <= 1'b1;
						wrote_q <= 1'b1;
						if (region_mem) begin
							cnt_q[eeprom_pkg::PAGE_BITS-1:0] <= page_low;
						end
						if (region_cfg) begin
							sel_q <= in_q[2:0];
						end
					end
					S_RDATA: begin
						drive_q <= 1'b0;
						cnt_q   <= cnt_q + 14'h0001;
					end
					default: begin
						state_q <= S_IDLE;
					end
				endcase
			end else if (state_q == S_RDATA && bit_q != 4'h0) begin
				drive_q <= ~out_q[out_idx];
			end
		end
	end

	// ========================================
	// Outputs
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = drive_q;
	assign standby         = (state_q == S_IDLE);
	assign write_busy      = (state_q == S_BUSY);
	assign sel_bits        = sel_q;
endmodule
`default_nettype wire

// >>> src/i2c_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface i2c_link_if;
	logic scl;         // Serial clock, driven by master
	logic sda;         // Resolved open-drain data line
	logic dev_sda_o;   // Device data out
	logic dev_sda_oe;  // Device pulls line
	logic host_sda_o;  // Master data out
	logic host_sda_oe; // Master pulls line

	// ========================================
	// Wired-AND with pull-up
	assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (output scl, input sda, output host_sda_o,
		output host_sda_oe);
endinterface
`default_nettype wire

// >>> verif/eeprom_link_sva.sv
`timescale 1ns/100ps
`default_nettype none
module eeprom_link_sva #(
	parameter int WRITE_CYCLES = 20
) (
	input wire logic       clk,         // System clock
	input wire logic       reset,       // Async reset, high
	input wire logic       scl,         // Bus clock
	input wire logic       sda,         // Resolved data
	input wire logic       dev_sda_o,   // Device data out
	input wire logic       dev_sda_oe,  // Device pulls
	input wire logic       host_sda_o,  // Master data out
	input wire logic       host_sda_oe, // Master pulls
	input wire logic       write_busy,  // Programming cycle
	input wire logic [2:0] sel_bits     // Select bits
);
	// ========================================
	// Bus tracking
	logic       scl_q, sda_q, first_q, rd_q, match_q;
	logic [3:0] cnt_q;
	logic [7:0] sr_q;
	logic [2:0] age_q;
	int         busy_q;
	wire rise = scl & ~scl_q;
	wire strt = scl & scl_q & sda_q & ~sda;
	wire stp = scl & scl_q & ~sda_q & sda;
	wire rise9 = rise & (cnt_q == 4'h8);
	wire ok = sr_q[7:1] == {eeprom_pkg::TYPE_CODE, sel_bits};
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{scl_q, sda_q, first_q, rd_q, match_q} <= 5'h18;
			{cnt_q, sr_q, age_q, busy_q} <= '0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			age_q <= stp ? 3'h0 : age_q + 3'(age_q != 3'h7);
			busy_q <= write_busy ? busy_q + 1 : 0;
			if (strt | stp) begin
				{cnt_q, first_q, match_q, rd_q} <= {4'h0, strt, 2'h0};
			end else if (rise) begin
				sr_q <= {sr_q[6:0], sda};
				cnt_q <= rise9 ? 4'h0 : cnt_q + 4'h1;
				if (rise9 & first_q) begin
					{first_q, match_q, rd_q} <= {1'b0, ok & ~write_busy, sr_q[0]};
				end
			end
		end
	end

	// ========================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence addr_s; rise9 && first_q; endsequence
	sequence body_s; rise9 && !first_q; endsequence
	sequence host_move_s;
		scl && $past(scl) && $changed(host_sda_oe);
	endsequence
	dev_low_only_a: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device drove data high");
	dev_shift_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("device changed data while clock high");
	addr_ack_a: assert property ((addr_s ##0 (ok && !write_busy)) |-> dev_sda_oe && !sda)
		else $error("matching address not acknowledged");
	addr_nack_a: assert property ((addr_s ##0 !ok) |-> !dev_sda_oe)
		else $error("mismatching address acknowledged");
	ignore_a: assert property ((body_s ##0 !match_q) |-> !dev_sda_oe)
		else $error("ignored transfer acknowledged");
	data_ack_a: assert property ((body_s ##0 (match_q && !rd_q)) |-> dev_sda_oe)
		else $error("written byte not acknowledged");
	busy_quiet_a: assert property (write_busy |-> !dev_sda_oe)
		else $error("device answered while programming");
	busy_len_a: assert property (busy_q <= WRITE_CYCLES + 1)
		else $error("programming cycle too long");
	busy_stop_a: assert property ($rose(write_busy) |-> age_q < 3'h4)
		else $error("programming began without a stop");
	host_low_a: assert property (host_sda_oe |-> !host_sda_o)
		else $error("master drove data high");
	host_shift_a: assert property (host_move_s |-> strt || stp)
		else $error("master changed data while clock high");
endmodule
`default_nettype wire

// >>> verif/tb_serial_eeprom_two_wire_slave.sv
`timescale 1ns/100ps
`default_nettype none
module tb_serial_eeprom_two_wire_slave;
	localparam int WC = 2500;
	logic clk, reset, cmd_valid, cmd_ack, cmd_ready, done, ack_seen;
	logic standby, write_busy;
	logic [7:0] cmd_data, rd_data;
	logic [2:0] sel_bits, sel;
	eeprom_pkg::op_t cmd_op;
	int n_fail, checks;
	i2c_link_if i2c_link_if_i ();
	eeprom_slave_end #(.WRITE_CYCLES(WC)) eeprom_slave_end_i (.clk(clk),
		.reset(reset), .link(i2c_link_if_i.device), .standby(standby),
		.write_busy(write_busy), .sel_bits(sel_bits));
	eeprom_master_end eeprom_master_end_i (.clk(clk), .reset(reset),
		.link(i2c_link_if_i.host), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.cmd_ack(cmd_ack), .done(done), .rd_data(rd_data),
		.ack_seen(ack_seen));
	eeprom_link_sva #(.WRITE_CYCLES(WC)) eeprom_link_sva_i (.clk(clk),
		.reset(reset), .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda),
		.dev_sda_o(i2c_link_if_i.dev_sda_o),
		.dev_sda_oe(i2c_link_if_i.dev_sda_oe),
		.host_sda_o(i2c_link_if_i.host_sda_o),
		.host_sda_oe(i2c_link_if_i.host_sda_oe),
		.write_busy(write_busy), .sel_bits(sel_bits));

	// ========================================
	// Helpers
	always #50 clk = ~clk;
	task automatic chk(input string nm, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic op(input eeprom_pkg::op_t o, input logic [7:0] d,
		input logic a);
		int k;
		k = 0;
		@(negedge clk);
		{cmd_valid, cmd_op, cmd_data, cmd_ack} = {1'b1, o, d, a};
		while (cmd_ready !== 1'b1 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 2000) n_fail++;
	endtask
	task automatic go();
		op(eeprom_pkg::OP_START, 8'h00, 1'b0);
	endtask
	task automatic sp();
		op(eeprom_pkg::OP_STOP, 8'h00, 1'b0);
	endtask
	task automatic wb(input logic [7:0] b, input logic e);
		op(eeprom_pkg::OP_WRITE, b, 1'b0);
		chk("ack", {7'h0, ack_seen}, {7'h0, e});
	endtask
	task automatic rb(input logic a, input logic [7:0] e);
		op(eeprom_pkg::OP_READ, 8'h00, a);
		chk("rd_data", rd_data, e);
	endtask
	task automatic da(input logic rw);
		go();
		wb({eeprom_pkg::TYPE_CODE, sel, rw}, 1'b1);
	endtask
	task automatic wa(input logic [13:0] a);
		wb({2'h0, a[13:8]}, 1'b1);
		wb(a[7:0], 1'b1);
	endtask
	task automatic settle();
		int k;
		for (k = 0; k < WC + 100 && write_busy !== 1'b0; k++) @(negedge clk);
		chk("standby", {7'h0, standby}, 8'h01);
	endtask

	// ========================================
	// Scenarios
	task automatic t_write();
		da(1'b0);
		wa(14'h0000);
		wb(8'h5a, 1'b1);
		sp();
		repeat (5) @(negedge clk);
		chk("busy", {7'h0, write_busy}, 8'h01);
		go();
		wb({eeprom_pkg::TYPE_CODE, sel, 1'b0}, 1'b0);
		sp();
		settle();
	endtask
	task automatic t_page();
		da(1'b0);
		wa(14'h3ffe);
		wb(8'ha1, 1'b1);
		wb(8'hb2, 1'b1);
		wb(8'hc3, 1'b1);
		sp();
		settle();
	endtask
	task automatic t_reads();
		da(1'b0);
		wa(14'h3fc0);
		da(1'b1);
		rb(1'b0, 8'hc3);
		sp();
		da(1'b0);
		wb(8'h00, 1'b1);
		da(1'b0);
		wa(14'h3ffe);
		da(1'b1);
		rb(1'b0, 8'ha1);
		sp();
		chk("standby", {7'h0, standby}, 8'h01);
		da(1'b1);
		rb(1'b1, 8'hb2);
		rb(1'b0, 8'h5a);
		sp();
	endtask
	task automatic t_mismatch();
		go();
		wb({eeprom_pkg::TYPE_CODE ^ 4'h8, sel, 1'b0}, 1'b0);
		wb(8'h00, 1'b0);
		sp();
		go();
		wb({eeprom_pkg::TYPE_CODE, sel ^ 3'h1, 1'b0}, 1'b0);
		sp();
	endtask
	task automatic t_config();
		da(1'b0);
		wb(8'h80, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h05, 1'b1);
		sp();
		settle();
		chk("sel_bits", {5'h0, sel_bits}, 8'h05);
		go();
		wb({eeprom_pkg::TYPE_CODE, sel, 1'b0}, 1'b0);
		op(eeprom_pkg::OP_RECOVER, 8'h00, 1'b0);
		sel = 3'h5;
		da(1'b0);
		wb(8'hc0, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h02, 1'b1);
		sp();
		settle();
		chk("sel_bits", {5'h0, sel_bits}, 8'h05);
	endtask

	task automatic conclude();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		{clk, reset, cmd_valid, cmd_ack, cmd_data, sel} = {2'h1, 13'h0000};
		cmd_op = eeprom_pkg::OP_START;
		{n_fail, checks} = '0;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		chk("standby", {7'h0, standby}, 8'h01);
		chk("sel_bits", {5'h0, sel_bits}, 8'h00);
		t_write();
		t_page();
		t_reads();
		t_mismatch();
		t_config();
		conclude();
	end
	initial begin
		#(90_000 * 100);
		n_fail++;
		conclude();
	end
endmodule
`default_nettype wire
